// File: design/rtcm_pkg.sv
// Constants of the 16-bit count/match timer register block.
// Assumes a byte-wide register port and one system clock.
// Contract
// - Counter readable and writable as low byte at 0x08, high byte at 0x09.
// - Counter equal to top value sets wrap flag and returns counter to zero.
// - Top value is 16 bits, low byte 0x0A, high byte 0x0B.
// - New top value acts two counter clocks after writing; software waits for idle.
// - Counter equal to match value sets the match flag.
// - Match value is 16 bits, low byte 0x0C, high byte 0x0D.
// - New match value acts two counter clocks after writing; software waits for idle.
// - Match value above top value never yields match interrupt or event.
// - Wrap interrupt uses vector word offset 0x00.
// - Match interrupt uses vector word offset 0x02.
// - Divider select 000 stops; 001..111 divide by 1,2,8,16,64,256,1024.
// - Events thinned: top 0 every third, top 1 every second, else every one.
// - Flags set on the count after the condition; cleared by vector or write one.
// - Busy flag high while counter, control, top or match is crossing.
`default_nettype none
package rtcm_pkg;
  localparam logic [3:0] OFS_CTRL  = 4'h0;
  localparam logic [3:0] OFS_STAT  = 4'h1;
  localparam logic [3:0] OFS_IRQSEL = 4'h2;
  localparam logic [3:0] OFS_PEND  = 4'h3;
  localparam logic [3:0] OFS_LATCH = 4'h4;
  localparam logic [3:0] OFS_CNTLO = 4'h8;
  localparam logic [3:0] OFS_CNTHI = 4'h9;
  localparam logic [3:0] OFS_TOPL  = 4'ha;
  localparam logic [3:0] OFS_TOPH  = 4'hb;
  localparam logic [3:0] OFS_MATL  = 4'hc;
  localparam logic [3:0] OFS_MATH  = 4'hd;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] VEC_WRAP  = 8'h00;
  localparam logic [7:0] VEC_MATCH = 8'h02;
  localparam int BIT_WRAP  = 0;
  localparam int BIT_MATCH = 1;
  localparam int BIT_BUSY  = 0;
  localparam int PRE_MSB   = 2;
  localparam int WLVL_LSB  = 0;
  localparam int MLVL_LSB  = 2;
  localparam logic [2:0] DIV_OFF = 3'h0;
  typedef enum logic [2:0] {
    SY_IDLE  = 3'b001,
    SY_WAIT2 = 3'b010,
    SY_WAIT1 = 3'b100
  } rtcm_sync_t;
endpackage
`default_nettype wire

// File: design/rtcm_top.sv
// Count/match timer: registers, prescaler, counter, flags, events.
// Assumes refClk is an asynchronous slow reference pin; strobes one cycle.
`timescale 1ns/10ps
`default_nettype none
module rtcm_top (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       refClk,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic       wrapVecAck,
  input  wire logic       matchVecAck,
  output logic      [7:0] regRdData,
  output logic            irq,
  output logic      [7:0] irqVecOfs,
  output logic            wrapEvent,
  output logic            matchEvent
);

  function automatic logic [9:0] divMask(input logic [2:0] sel);
    unique case (sel)
      3'h2:    divMask = 10'h001;
      3'h3:    divMask = 10'h007;
      3'h4:    divMask = 10'h00f;
      3'h5:    divMask = 10'h03f;
      3'h6:    divMask = 10'h0ff;
      3'h7:    divMask = 10'h3ff;
      default: divMask = 10'h000;
    endcase
  endfunction

  function automatic logic [1:0] thinPeriod(input logic [15:0] top);
    if (top == 16'h0000)
      thinPeriod = 2'h3;
    else if (top == 16'h0001)
      thinPeriod = 2'h2;
    else
      thinPeriod = 2'h1;
  endfunction

  logic [1:0]  rstSync_r;
  logic        rstN;
  logic        refS1_r, refS2_r, refS3_r, refLvl_r;
  logic        refRise;
  logic [9:0]  preCnt_r;
  logic        tick;
  logic [2:0]  ctrlSys_r, ctrlAct_r;
  logic [15:0] cntSys_r, cntAct_r;
  logic [15:0] topSys_r, topAct_r;
  logic [15:0] matSys_r, matAct_r;
  logic [3:0]  irqSel_r;
  logic [1:0]  pend_r;
  logic [7:0]  latch_r;
  logic        pendCnt_r, pendTop_r, pendMat_r, pendCtl_r;
  rtcm_pkg::rtcm_sync_t syncSt_r;
  logic        applyNow, busy;
  logic        wrapHit, matchHit;
  logic [1:0]  hit, evNxt, en, clr;
  logic [7:0]  rdMux;
  logic        wrCtl, wrCntH, wrTopH, wrMatH, hiWr;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      rstSync_r <= 2'h0;
    else
      rstSync_r <= {rstSync_r[0], 1'b1};
  assign rstN = rstSync_r[1];

  // Third stage filters: edge counts only once second and third agree
  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      refS1_r  <= 1'b0;
      refS2_r  <= 1'b0;
      refS3_r  <= 1'b0;
      refLvl_r <= 1'b0;
    end
    else
    begin
      refS1_r <= refClk;
      refS2_r <= refS1_r;
      refS3_r <= refS2_r;
      if (refS2_r == refS3_r)
        refLvl_r <= refS3_r;
    end
  assign refRise = refS2_r & refS3_r & ~refLvl_r;

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      preCnt_r <= 10'h000;
    else if (refRise)
      preCnt_r <= preCnt_r + 10'h001;

  assign tick = refRise && (ctrlAct_r != rtcm_pkg::DIV_OFF) &&
                ((preCnt_r & divMask(ctrlAct_r)) == divMask(ctrlAct_r));

  assign wrCtl  = regWr && regAddr == rtcm_pkg::OFS_CTRL;
  assign wrCntH = regWr && regAddr == rtcm_pkg::OFS_CNTHI;
  assign wrTopH = regWr && regAddr == rtcm_pkg::OFS_TOPH;
  assign wrMatH = regWr && regAddr == rtcm_pkg::OFS_MATH;
  assign hiWr   = wrCtl || wrCntH || wrTopH || wrMatH;

  // High byte commits the pair held in the latch
  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      ctrlSys_r <= 3'h0;
      cntSys_r  <= rtcm_pkg::RST_WORD;
      topSys_r  <= rtcm_pkg::RST_WORD;
      matSys_r  <= rtcm_pkg::RST_WORD;
      irqSel_r  <= 4'h0;
    end
    else if (regWr)
    begin
      if (wrCtl)
        ctrlSys_r <= regWrData[rtcm_pkg::PRE_MSB:0];
      if (wrCntH)
        cntSys_r <= {regWrData, latch_r};
      if (wrTopH)
        topSys_r <= {regWrData, latch_r};
      if (wrMatH)
        matSys_r <= {regWrData, latch_r};
      if (regAddr == rtcm_pkg::OFS_IRQSEL)
        irqSel_r <= regWrData[3:0];
    end

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      latch_r <= rtcm_pkg::RST_BYTE;
    else if (regWr && (regAddr == rtcm_pkg::OFS_CNTLO || regAddr == rtcm_pkg::OFS_TOPL ||
             regAddr == rtcm_pkg::OFS_MATL || regAddr == rtcm_pkg::OFS_LATCH))
      latch_r <= regWrData;
    else if (regRd && regAddr == rtcm_pkg::OFS_CNTLO)
      latch_r <= cntAct_r[15:8];
    else if (regRd && regAddr == rtcm_pkg::OFS_TOPL)
      latch_r <= topSys_r[15:8];
    else if (regRd && regAddr == rtcm_pkg::OFS_MATL)
      latch_r <= matSys_r[15:8];

  // Crossing: applied on the second reference edge after the write
  // A control or high-byte write during the wait restarts it, so a busy poll may stall a while
  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      syncSt_r <= rtcm_pkg::SY_IDLE;
    else if (hiWr)
      syncSt_r <= rtcm_pkg::SY_WAIT2;
    else if (refRise)
    begin
      unique case (syncSt_r)
        rtcm_pkg::SY_IDLE:  syncSt_r <= rtcm_pkg::SY_IDLE;
        rtcm_pkg::SY_WAIT2: syncSt_r <= rtcm_pkg::SY_WAIT1;
        rtcm_pkg::SY_WAIT1: syncSt_r <= rtcm_pkg::SY_IDLE;
        default:            syncSt_r <= rtcm_pkg::SY_IDLE;
      endcase
    end
  assign applyNow = refRise && syncSt_r == rtcm_pkg::SY_WAIT1 && !hiWr;
  assign busy     = syncSt_r != rtcm_pkg::SY_IDLE;

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      pendCnt_r <= 1'b0;
      pendTop_r <= 1'b0;
      pendMat_r <= 1'b0;
      pendCtl_r <= 1'b0;
    end
    else if (applyNow)
    begin
      pendCnt_r <= 1'b0;
      pendTop_r <= 1'b0;
      pendMat_r <= 1'b0;
      pendCtl_r <= 1'b0;
    end
    else
    begin
      pendCnt_r <= pendCnt_r | wrCntH;
      pendTop_r <= pendTop_r | wrTopH;
      pendMat_r <= pendMat_r | wrMatH;
      pendCtl_r <= pendCtl_r | wrCtl;
    end

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      ctrlAct_r <= 3'h0;
      topAct_r  <= rtcm_pkg::RST_WORD;
      matAct_r  <= rtcm_pkg::RST_WORD;
    end
    else if (applyNow)
    begin
      if (pendCtl_r)
        ctrlAct_r <= ctrlSys_r;
      if (pendTop_r)
        topAct_r <= topSys_r;
      if (pendMat_r)
        matAct_r <= matSys_r;
    end

  assign wrapHit  = tick && cntAct_r == topAct_r;
  assign matchHit = tick && cntAct_r == matAct_r && matAct_r <= topAct_r;

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      cntAct_r <= rtcm_pkg::RST_WORD;
    else if (applyNow && pendCnt_r)
      cntAct_r <= cntSys_r;
    else if (wrapHit)
      cntAct_r <= 16'h0000;
    else if (tick)
      cntAct_r <= cntAct_r + 16'h0001;

  assign hit = {matchHit, wrapHit};
  assign clr = ({2{regWr && regAddr == rtcm_pkg::OFS_PEND}} & regWrData[1:0]) |
               {matchVecAck, wrapVecAck};

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      pend_r <= 2'h0;
    else
      pend_r <= (pend_r & ~clr) | hit;

  // Events see fewer edges when the period is too short to cross
  for (genvar g = 0; g < 2; g++)
  begin : gThin
    logic [1:0] thin_r;
    always_ff @(posedge clk or negedge rstN)
      if (!rstN)
        thin_r <= 2'h0;
      else if (hit[g])
        thin_r <= (thin_r + 2'h1 >= thinPeriod(topAct_r)) ? 2'h0 : thin_r + 2'h1;
    assign evNxt[g] = hit[g] && (thin_r == 2'h0 || thinPeriod(topAct_r) == 2'h1);
  end

  assign en = {|irqSel_r[rtcm_pkg::MLVL_LSB+:2], |irqSel_r[rtcm_pkg::WLVL_LSB+:2]};

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      irq        <= 1'b0;
      irqVecOfs  <= rtcm_pkg::VEC_WRAP;
      wrapEvent  <= 1'b0;
      matchEvent <= 1'b0;
    end
    else
    begin
      irq        <= |(pend_r & en);
      wrapEvent  <= evNxt[rtcm_pkg::BIT_WRAP];
      matchEvent <= evNxt[rtcm_pkg::BIT_MATCH];
      if (pend_r[rtcm_pkg::BIT_WRAP] && en[rtcm_pkg::BIT_WRAP])
        irqVecOfs <= rtcm_pkg::VEC_WRAP;
      else if (pend_r[rtcm_pkg::BIT_MATCH] && en[rtcm_pkg::BIT_MATCH])
        irqVecOfs <= rtcm_pkg::VEC_MATCH;
    end

  always_comb
  begin
    rdMux = rtcm_pkg::RST_BYTE;
    unique case (regAddr)
      rtcm_pkg::OFS_CTRL:   rdMux = {5'h00, ctrlSys_r};
      rtcm_pkg::OFS_STAT:   rdMux = {7'h00, busy};
      rtcm_pkg::OFS_IRQSEL: rdMux = {4'h0, irqSel_r};
      rtcm_pkg::OFS_PEND:   rdMux = {6'h00, pend_r};
      rtcm_pkg::OFS_LATCH:  rdMux = latch_r;
      rtcm_pkg::OFS_CNTLO:  rdMux = cntAct_r[7:0];
      rtcm_pkg::OFS_TOPL:   rdMux = topSys_r[7:0];
      rtcm_pkg::OFS_MATL:   rdMux = matSys_r[7:0];
      rtcm_pkg::OFS_CNTHI,
      rtcm_pkg::OFS_TOPH,
      rtcm_pkg::OFS_MATH:   rdMux = latch_r;
      default:              rdMux = rtcm_pkg::RST_BYTE;
    endcase
  end

  // Data only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      regRdData <= rtcm_pkg::RST_BYTE;
    else
      regRdData <= regRd ? rdMux : rtcm_pkg::RST_BYTE;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  sequence s_wrTopL;
    regWr && regAddr == rtcm_pkg::OFS_TOPL;
  endsequence
  sequence s_wrTopH;
    regWr && regAddr == rtcm_pkg::OFS_TOPH;
  endsequence

  property p_wrapClear;
    wrapHit && !(applyNow && pendCnt_r) |=> cntAct_r == 16'h0000;
  endproperty
  a_wrapClear: assert property (p_wrapClear) else $error("wrap did not clear counter");

  property p_wrapFlag;
    wrapHit |=> pend_r[0] ##1 (pend_r[0] || $past(clr[0]));
  endproperty
  a_wrapFlag: assert property (p_wrapFlag) else $error("wrap flag not set");

  property p_matchNever;
    $rose(pend_r[1]) |-> $past(matAct_r) <= $past(topAct_r);
  endproperty
  a_matchNever: assert property (p_matchNever) else $error("match above top flagged");

  property p_topApply;
    applyNow && pendTop_r |=> topAct_r == $past(topSys_r) && !busy;
  endproperty
  a_topApply: assert property (p_topApply) else $error("top value not applied");

  property p_busyRead;
    regRd && regAddr == rtcm_pkg::OFS_STAT && busy |=> regRdData[0];
  endproperty
  a_busyRead: assert property (p_busyRead) else $error("busy not reported");

  property p_lowRead;
    regRd && regAddr == rtcm_pkg::OFS_CNTLO |=> regRdData == $past(cntAct_r[7:0]);
  endproperty
  a_lowRead: assert property (p_lowRead) else $error("counter low byte wrong");

  property p_vecWrap;
    pend_r[0] && en[0] |=> irqVecOfs == rtcm_pkg::VEC_WRAP && irq;
  endproperty
  a_vecWrap: assert property (p_vecWrap) else $error("wrap vector wrong");

  property p_vecMatch;
    pend_r == 2'b10 && en[1] |=> irqVecOfs == rtcm_pkg::VEC_MATCH && irq;
  endproperty
  a_vecMatch: assert property (p_vecMatch) else $error("match vector wrong");

  property p_stopped;
    ctrlAct_r == rtcm_pkg::DIV_OFF |-> !tick ##1 $stable(cntAct_r) || $past(applyNow);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter ran while stopped");

  property p_commit;
    s_wrTopL ##1 s_wrTopH |=> topSys_r == {$past(regWrData), $past(regWrData, 2)};
  endproperty
  a_commit: assert property (p_commit) else $error("top pair not committed");

  property p_cntStart;
    regWr && regAddr == rtcm_pkg::OFS_CNTHI |=> busy && pendCnt_r;
  endproperty
  a_cntStart: assert property (p_cntStart) else $error("counter crossing not started");

  property p_wrapEvEvery;
    wrapHit && topAct_r >= 16'h0002 |=> wrapEvent;
  endproperty
  a_wrapEvEvery: assert property (p_wrapEvEvery) else $error("wrap event dropped");

  property p_matchEvEvery;
    matchHit && topAct_r >= 16'h0002 |=> matchEvent;
  endproperty
  a_matchEvEvery: assert property (p_matchEvEvery) else $error("match event dropped");

  property p_wrapEvThin;
    wrapHit && topAct_r == 16'h0000 && gThin[0].thin_r != 2'h0 |=> !wrapEvent;
  endproperty
  a_wrapEvThin: assert property (p_wrapEvThin) else $error("wrap event not thinned");

  property p_cntApply;
    applyNow && pendCnt_r |=> cntAct_r == $past(cntSys_r);
  endproperty
  a_cntApply: assert property (p_cntApply) else $error("counter value not applied");

  property p_matApply;
    applyNow && pendMat_r |=> matAct_r == $past(matSys_r) && !busy;
  endproperty
  a_matApply: assert property (p_matApply) else $error("match value not applied");

  property p_ctlBusy;
    wrCtl |=> busy;
  endproperty
  a_ctlBusy: assert property (p_ctlBusy) else $error("control crossing not flagged");

endmodule // rtcm_top
`default_nettype wire

// File: tb/tb_rtcm_top.sv
// Self-checking bench for the count/match timer register block.
// Assumes rtcm_top and rtcm_pkg are compiled first; bench makes clk and refClk.
`timescale 1ns/10ps
`default_nettype none
module tb_rtcm_top;
  logic       clk         = 1'b0;
  logic       arst_n      = 1'b0;
  logic       refClk      = 1'b0;
  logic [3:0] regAddr     = 4'h0;
  logic [7:0] regWrData   = 8'h00;
  logic       regWr       = 1'b0;
  logic       regRd       = 1'b0;
  logic       wrapVecAck  = 1'b0;
  logic       matchVecAck = 1'b0;
  logic [7:0] regRdData;
  logic       irq;
  logic [7:0] irqVecOfs;
  logic       wrapEvent;
  logic       matchEvent;
  int         n_fail      = 0;
  int         num_checks  = 0;
  int         nWrap       = 0;
  int         nMatch      = 0;

  always #20 clk = ~clk;

  rtcm_top dut (.clk(clk), .arst_n(arst_n), .refClk(refClk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .wrapVecAck(wrapVecAck), .matchVecAck(matchVecAck),
    .regRdData(regRdData), .irq(irq), .irqVecOfs(irqVecOfs), .wrapEvent(wrapEvent), .matchEvent(matchEvent));

  always @(posedge clk)
  begin
    if (wrapEvent === 1'b1)
      nWrap++;
    if (matchEvent === 1'b1)
      nMatch++;
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkCnt(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr     <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk8(what, exp, d);
  endtask

  // Low byte first: the high write commits both
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= v[7:0];
    regWr     <= 1'b1;
    @(posedge clk);
    regAddr   <= a + 4'h1;
    regWrData <= v[15:8];
    @(posedge clk);
    regWr     <= 1'b0;
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 4'h1, v[15:8]);
  endtask

  // Reference edges kept 4 clk wide, above the 3-flop sync need
  task automatic tick(input int n);
    repeat (n)
    begin
      refClk <= 1'b1;
      repeat (4) @(posedge clk);
      refClk <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic waitIdle();
    logic [7:0] s;
    int         i;
    for (i = 0; i < 12; i++)
    begin
      rd(rtcm_pkg::OFS_STAT, s);
      if (s[rtcm_pkg::BIT_BUSY] === 1'b0)
        break;
      tick(1);
    end
    chk8("busy cleared", 8'h00, s);
  endtask

  task automatic t_reset();
    rdChk(rtcm_pkg::OFS_CTRL, 8'h00, "ctrl reset");
    rdChk(rtcm_pkg::OFS_PEND, 8'h00, "flags reset");
    rdChk(rtcm_pkg::OFS_CNTLO, 8'h00, "count low reset");
    rdChk(rtcm_pkg::OFS_MATL, 8'h00, "match low reset");
    rdChk(4'h5, 8'h00, "unmapped read");
    wr(rtcm_pkg::OFS_STAT, 8'hff);
    rdChk(rtcm_pkg::OFS_STAT, 8'h00, "status read only");
    chk8("irq reset", 8'h00, {7'h00, irq});
    $display("test reset done");
  endtask

  task automatic t_count();
    wr16(rtcm_pkg::OFS_CNTLO, 16'h1234);
    rdChk(rtcm_pkg::OFS_STAT, 8'h01, "busy during count crossing");
    waitIdle();
    tick(4);
    rdChk(rtcm_pkg::OFS_CNTLO, 8'h34, "count low");
    rdChk(rtcm_pkg::OFS_CNTHI, 8'h12, "count high");
    wr(rtcm_pkg::OFS_MATL, 8'h5a);
    rdChk(rtcm_pkg::OFS_LATCH, 8'h5a, "byte latch");
    $display("test count done");
  endtask

  task automatic t_div();
    logic [15:0] a;
    logic [15:0] b;
    int          d;
    int          n[8]  = '{32, 32, 32, 32, 32, 64, 256, 1024};
    int          ex[8] = '{0, 32, 16, 4, 2, 1, 1, 1};
    wr16(rtcm_pkg::OFS_TOPL, 16'hffff);
    rdChk(rtcm_pkg::OFS_STAT, 8'h01, "busy during top crossing");
    waitIdle();
    rdChk(rtcm_pkg::OFS_TOPL, 8'hff, "top low");
    rdChk(rtcm_pkg::OFS_TOPH, 8'hff, "top high");
    for (d = 0; d < 8; d++)
    begin
      wr(rtcm_pkg::OFS_CTRL, d[7:0]);
      waitIdle();
      rd16(rtcm_pkg::OFS_CNTLO, a);
      tick(n[d]);
      rd16(rtcm_pkg::OFS_CNTLO, b);
      chkCnt("divided ticks", ex[d], ex[d], int'(b - a));
    end
    $display("test divider done");
  endtask

  task automatic t_irq();
    int i;
    wr(rtcm_pkg::OFS_CTRL, 8'h01);
    wr16(rtcm_pkg::OFS_TOPL, 16'h0005);
    wr16(rtcm_pkg::OFS_MATL, 16'h0003);
    wr16(rtcm_pkg::OFS_CNTLO, 16'h0000);
    waitIdle();
    rdChk(rtcm_pkg::OFS_MATL, 8'h03, "match low");
    rdChk(rtcm_pkg::OFS_MATH, 8'h00, "match high");
    wr(rtcm_pkg::OFS_PEND, 8'h03);
    wr(rtcm_pkg::OFS_IRQSEL, 8'h01);
    nWrap  = 0;
    nMatch = 0;
    for (i = 0; i < 10 && nWrap == 0; i++)
      tick(1);
    repeat (4) @(posedge clk);
    chkCnt("match events", 1, 1, nMatch);
    rdChk(rtcm_pkg::OFS_PEND, 8'h03, "flags after wrap");
    chk8("irq on wrap", 8'h01, {7'h00, irq});
    chk8("wrap vector", rtcm_pkg::VEC_WRAP, irqVecOfs);
    @(posedge clk);
    wrapVecAck <= 1'b1;
    @(posedge clk);
    wrapVecAck <= 1'b0;
    rdChk(rtcm_pkg::OFS_PEND, 8'h02, "wrap cleared by vector");
    chk8("irq match masked", 8'h00, {7'h00, irq});
    wr(rtcm_pkg::OFS_IRQSEL, 8'h0c);
    repeat (3) @(posedge clk);
    chk8("irq on match", 8'h01, {7'h00, irq});
    chk8("match vector", rtcm_pkg::VEC_MATCH, irqVecOfs);
    wr(rtcm_pkg::OFS_PEND, 8'h02);
    rdChk(rtcm_pkg::OFS_PEND, 8'h00, "match cleared by write");
    chk8("irq cleared", 8'h00, {7'h00, irq});
    $display("test interrupt done");
  endtask

  // Count placed between top and match so only a faulty match path fires
  task automatic t_nomatch();
    wr16(rtcm_pkg::OFS_MATL, 16'h0007);
    wr16(rtcm_pkg::OFS_CNTLO, 16'h0006);
    waitIdle();
    wr(rtcm_pkg::OFS_PEND, 8'h03);
    nMatch = 0;
    tick(8);
    repeat (4) @(posedge clk);
    chkCnt("match above top events", 0, 0, nMatch);
    rdChk(rtcm_pkg::OFS_PEND, 8'h00, "no match flag");
    chk8("no match irq", 8'h00, {7'h00, irq});
    $display("test match above top done");
  endtask

  task automatic t_thin(input logic [15:0] top, input int lo, input int hi);
    wr16(rtcm_pkg::OFS_TOPL, top);
    wr16(rtcm_pkg::OFS_MATL, 16'h0000);
    wr16(rtcm_pkg::OFS_CNTLO, 16'h0000);
    waitIdle();
    nWrap  = 0;
    nMatch = 0;
    tick(30);
    repeat (6) @(posedge clk);
    chkCnt("thinned wraps", lo, hi, nWrap);
    chkCnt("thinned matches", lo, hi, nMatch);
    @(posedge clk);
    matchVecAck <= 1'b1;
    @(posedge clk);
    matchVecAck <= 1'b0;
    rdChk(rtcm_pkg::OFS_PEND, 8'h01, "match cleared by vector");
    wr(rtcm_pkg::OFS_PEND, 8'h01);
    rdChk(rtcm_pkg::OFS_PEND, 8'h00, "wrap cleared by write");
    $display("test thinning done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run is near 13.5k clk; limit leaves wide margin
  initial
  begin
    #2000000;
    n_fail++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_count();
    t_div();
    t_irq();
    t_nomatch();
    t_thin(16'h0000, 9, 11);
    t_thin(16'h0001, 6, 9);
    t_thin(16'h0002, 9, 11);
    results();
  end
endmodule // tb_rtcm_top
`default_nettype wire
